// ==== design/mig_defs.svh ====
// Constants for the maskable interrupt gate: widths, status word layout,
// reset values and the source count.
// Assumes it is included by bare name from every design file that needs it.
`ifndef MIG_DEFS_SVH
`define MIG_DEFS_SVH

// Number of maskable request sources and the width of their index.
`define MIG_NUM_SRC      8
`define MIG_IDX_W        3

// Program status word layout, as seen by a system register load.
`define MIG_PSW_W        32
`define MIG_PSW_HOLD_BIT 5

// System register index that addresses the program status word.
`define MIG_SYSREG_W     5
`define MIG_SYSREG_PSW   5'h05

// Reset values.
`define MIG_HOLD_RST     1'b1
`define MIG_IDX_RST      3'h0

`endif

// ==== design/mig_pkg.sv ====
// Types shared by the maskable interrupt gate and its testbench.
// Assumes mig_defs.svh is on the include path.
`include "mig_defs.svh"

package mig_pkg;

	// Instruction classes that touch the mask hold flag.
	typedef enum logic [1:0] {
		MIG_OP_MASK_SET   = 2'h0,
		MIG_OP_MASK_CLEAR = 2'h1,
		MIG_OP_RETURN     = 2'h2,
		MIG_OP_SYSREG_LD  = 2'h3
	} mig_op_type;

	// One retiring instruction from the execution stage.
	typedef struct packed {
		logic                       valid;
		mig_op_type                 op;
		logic [`MIG_SYSREG_W-1:0]   sysreg;
		logic [`MIG_PSW_W-1:0]      data;
	} mig_instr_type;

endpackage : mig_pkg

// ==== design/mig_pick.sv ====
// Fixed priority selector over the maskable request pending flags.
// Assumes the flags are levels held by their sources until acknowledged.
`timescale 1ns/1ps
`default_nettype none
`include "mig_defs.svh"

module mig_pick (
	// Pending flags from the sources
	input  wire logic [`MIG_NUM_SRC-1:0] req,
	// Selection
	output logic                         any,
	output logic [`MIG_IDX_W-1:0]        idx,
	output logic [`MIG_NUM_SRC-1:0]      onehot
);

	// *****************************************************************
	// Selection
	// *****************************************************************

	// Lowest index wins; it is also the fairest cheap choice here.
	function automatic logic [`MIG_IDX_W-1:0] lowest_idx(
		input logic [`MIG_NUM_SRC-1:0] r
	);
		logic [`MIG_IDX_W-1:0] k;
		k = `MIG_IDX_RST;
		for (int i = `MIG_NUM_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				k = i[`MIG_IDX_W-1:0];
			end
		end
		return k;
	endfunction : lowest_idx

	wire [`MIG_NUM_SRC-1:0] lowest_bit = req & (~req + `MIG_NUM_SRC'(1));

	assign any    = |req;
	assign idx    = lowest_idx(req);
	assign onehot = lowest_bit;

endmodule : mig_pick
`default_nettype wire

// ==== design/mig_gate.sv ====
// Maskable interrupt gate: holds the mask hold flag of the program status
// word and decides which request is acknowledged in each cycle.
// Assumes instructions arrive as one retiring instruction per cycle and
// request sources hold their pending flag until their clear pulse.
//
// Overview of operation
// RULE_01: Flag at 0 lets maskable requests through; at 1 holds them pending.
// RULE_02: The mask set instruction sets the flag; mask clear clears it.
// RULE_03: Handler return clears the flag; status word load writes it.
// RULE_04: Non-maskable requests and exceptions are acknowledged regardless.
// RULE_05: Acknowledging a maskable request sets the flag by hardware.
// RULE_06: A held request stays pending and is taken once the flag clears.
`timescale 1ns/1ps
`default_nettype none
`include "mig_defs.svh"

module mig_gate (
	// Clock, reset, enable
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	// Execution stage
	input  wire mig_pkg::mig_instr_type       instr,
	// Request sources
	input  wire logic [`MIG_NUM_SRC-1:0]      req_pending,
	input  wire logic                         nmi_req,
	input  wire logic                         exc_req,
	// Acknowledge handshakes
	output logic                              exc_ack,
	output logic                              nmi_ack,
	output logic                              mask_ack,
	output logic [`MIG_NUM_SRC-1:0]           pending_clr,
	// Registered state
	output logic [`MIG_IDX_W-1:0]             ack_source,
	output logic                              mask_hold_flag
);

	// *****************************************************************
	// Request selection
	// *****************************************************************

	logic                         pick_any;
	logic [`MIG_IDX_W-1:0]        pick_idx;
	logic [`MIG_NUM_SRC-1:0]      pick_onehot;

	mig_pick u_pick (
		.req    (req_pending),
		.any    (pick_any),
		.idx    (pick_idx),
		.onehot (pick_onehot)
	);

	// *****************************************************************
	// Acknowledge decision
	// *****************************************************************

	// Exceptions outrank non-maskable requests, which outrank maskable
	// ones. Only one acknowledge is given per cycle so that the handler
	// entry sequence upstream never sees two at once.
	// RULE_04 acknowledge not gated by the flag
	assign exc_ack = ce && exc_req;
	assign nmi_ack = ce && nmi_req && !exc_req;

	// A held request is simply not acknowledged; its source keeps its flag
	// set, so it is taken in the first enabled cycle the flag reads zero with no exception or non-maskable request.
	// RULE_01 flag gates acknowledge
	// RULE_06 pending request released
	assign mask_ack = ce && pick_any && !mask_hold_flag
		&& !exc_req && !nmi_req;

	assign pending_clr = mask_ack ? pick_onehot : '0;

	// *****************************************************************
	// Flag update
	// *****************************************************************

	wire is_set    = instr.valid && (instr.op == mig_pkg::MIG_OP_MASK_SET);
	wire is_clear  = instr.valid && (instr.op == mig_pkg::MIG_OP_MASK_CLEAR);
	wire is_return = instr.valid && (instr.op == mig_pkg::MIG_OP_RETURN);
	wire is_load   = instr.valid && (instr.op == mig_pkg::MIG_OP_SYSREG_LD)
		&& (instr.sysreg == `MIG_SYSREG_PSW);
	wire load_bit  = instr.data[`MIG_PSW_HOLD_BIT];

	logic next_mask_hold;

	always_comb begin
		next_mask_hold = mask_hold_flag;
		// RULE_02 set and clear instructions
		if (is_set) begin
			next_mask_hold = 1'b1;
		end else if (is_clear) begin
			next_mask_hold = 1'b0;
		// RULE_03 return and status load
		end else if (is_return) begin
			next_mask_hold = 1'b0;
		end else if (is_load) begin
			next_mask_hold = load_bit;
		end
		// The hardware set wins over any clear in the same cycle, so an
		// acknowledged request can never be entered with the gate open.
		// RULE_05 automatic set
		if (mask_ack) begin
			next_mask_hold = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_hold_flag <= `MIG_HOLD_RST;
		end else if (ce) begin
			mask_hold_flag <= next_mask_hold;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_source <= `MIG_IDX_RST;
		end else if (ce && mask_ack) begin
			ack_source <= pick_idx;
		end
	end

	// *****************************************************************
	// Assertions
	// *****************************************************************

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (rst);

	wire quiet_high = !exc_req && !nmi_req;

	sequence s_held;
		mask_hold_flag && (|req_pending);
	endsequence

	sequence s_open;
		ce && !mask_hold_flag && (|req_pending) && quiet_high;
	endsequence

	a_masked_no_ack: assert property ( // RULE_01
		mask_hold_flag |-> !mask_ack && (pending_clr == '0))
		else $error("maskable acknowledge while flag set");

	a_open_takes_req: assert property ( // RULE_01
		s_open |-> mask_ack && $onehot(pending_clr))
		else $error("open gate failed to acknowledge");

	a_set_instr_sets: assert property ( // RULE_02
		ce && is_set |=> mask_hold_flag)
		else $error("mask set instruction did not set flag");

	a_clear_instr: assert property ( // RULE_02
		ce && is_clear && !mask_ack |=> !mask_hold_flag)
		else $error("mask clear instruction did not clear flag");

	a_return_clears: assert property ( // RULE_03
		ce && is_return && !mask_ack |=> !mask_hold_flag)
		else $error("handler return did not clear flag");

	a_load_writes: assert property ( // RULE_03
		ce && is_load && !mask_ack |=> mask_hold_flag == $past(load_bit))
		else $error("status load did not write flag");

	a_nmi_exc_ack: assert property ( // RULE_04
		ce && (nmi_req || exc_req) |-> (exc_ack || nmi_ack) && !mask_ack)
		else $error("high priority request not acknowledged");

	a_auto_set: assert property ( // RULE_05
		mask_ack |=> mask_hold_flag && ack_source == $past(pick_idx))
		else $error("acknowledge did not set flag or record source");

	a_held_release: assert property ( // RULE_06
		s_held ##1 s_held ##1 s_open |-> mask_ack)
		else $error("held request not taken after flag cleared");

	a_ce_freeze: assert property (
		!ce |=> $stable(mask_hold_flag) && $stable(ack_source))
		else $error("state moved while clock enable low");

endmodule : mig_gate
`default_nettype wire

// ==== tb/mig_src.sv ====
// Model of the maskable request sources, one pending flag per source.
// Assumes the gate clears a flag through its one-hot clear pulse.
`timescale 1ns/1ps
`default_nettype none
`include "mig_defs.svh"

module mig_src (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Raise pulses from the bench, clear pulses from the gate
	input  wire logic [`MIG_NUM_SRC-1:0] raise,
	input  wire logic [`MIG_NUM_SRC-1:0] pending_clr,
	// Pending flags
	output logic      [`MIG_NUM_SRC-1:0] req_pending
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_pending <= '0;
		end else begin
			req_pending <= (req_pending | raise) & ~pending_clr;
		end
	end
endmodule : mig_src
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the maskable interrupt gate.
// Assumes the source model drives the pending flags.
`timescale 1ns/1ps
`default_nettype none
`include "mig_defs.svh"

module tb_top;
	logic                    clk     = 1'b0;
	logic                    rst     = 1'b1;
	logic                    ce      = 1'b1;
	logic                    nmi_req = 1'b0;
	logic                    exc_req = 1'b0;
	logic [`MIG_NUM_SRC-1:0] raise   = '0;
	mig_pkg::mig_instr_type  instr   = '0;
	wire logic [`MIG_NUM_SRC-1:0] req_pending;
	wire logic [`MIG_NUM_SRC-1:0] pending_clr;
	wire logic                    exc_ack;
	wire logic                    nmi_ack;
	wire logic                    mask_ack;
	wire logic                    mask_hold_flag;
	wire logic [`MIG_IDX_W-1:0]   ack_source;
	int                           n_mismatch = 0;
	int                           tests_run  = 0;

	always #12.5 clk = ~clk;

	mig_gate dut_u (.clk(clk), .rst(rst), .ce(ce), .instr(instr),
		.req_pending(req_pending), .nmi_req(nmi_req), .exc_req(exc_req),
		.exc_ack(exc_ack), .nmi_ack(nmi_ack), .mask_ack(mask_ack),
		.pending_clr(pending_clr), .ack_source(ack_source),
		.mask_hold_flag(mask_hold_flag));
	mig_src src_u (.clk(clk), .rst(rst), .raise(raise),
		.pending_clr(pending_clr), .req_pending(req_pending));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// The instruction is taken at the second edge, checked at the negedge.
	task do_op(input mig_pkg::mig_op_type op,
		input logic [`MIG_SYSREG_W-1:0] sr,
		input logic [31:0] d);
		@(posedge clk);
		instr <= '{1'b1, op, sr, d};
		@(posedge clk);
		instr.valid <= 1'b0;
		@(negedge clk);
	endtask : do_op

	task raise_req(input logic [`MIG_NUM_SRC-1:0] v);
		@(posedge clk);
		raise <= v;
		@(posedge clk);
		raise <= '0;
		@(negedge clk);
	endtask : raise_req

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task t_instr;
		chk(mask_hold_flag, 1'b1);
		do_op(mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0);
		chk(mask_hold_flag, 1'b0);
		do_op(mig_pkg::MIG_OP_MASK_SET, 5'h00, 32'h0);
		chk(mask_hold_flag, 1'b1);
		do_op(mig_pkg::MIG_OP_SYSREG_LD, 5'h04, 32'h0);
		chk(mask_hold_flag, 1'b1);
		do_op(mig_pkg::MIG_OP_SYSREG_LD, `MIG_SYSREG_PSW, 32'hffffffdf);
		chk(mask_hold_flag, 1'b0);
		do_op(mig_pkg::MIG_OP_SYSREG_LD, `MIG_SYSREG_PSW, 32'h20);
		chk(mask_hold_flag, 1'b1);
		$display("test instr done");
	endtask : t_instr

	task t_pend;
		raise_req(8'h06);
		chk(mask_ack, 1'b0);
		chk(req_pending, 8'h06);
		do_op(mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0);
		chk(pending_clr, 8'h02);
		@(negedge clk);
		chk({mask_hold_flag, ack_source}, 4'h9);
		chk({mask_ack, req_pending}, 9'h004);
		do_op(mig_pkg::MIG_OP_RETURN, 5'h00, 32'h0);
		chk(pending_clr, 8'h04);
		@(negedge clk);
		chk({mask_hold_flag, ack_source}, 4'ha);
		$display("test pend done");
	endtask : t_pend

	task t_nmi;
		@(posedge clk);
		nmi_req <= 1'b1;
		@(negedge clk);
		chk({exc_ack, nmi_ack}, 2'h1);
		@(posedge clk);
		exc_req <= 1'b1;
		@(negedge clk);
		chk({exc_ack, nmi_ack}, 2'h2);
		raise_req(8'h81);
		do_op(mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0);
		chk(mask_ack, 1'b0);
		@(posedge clk);
		exc_req <= 1'b0;
		nmi_req <= 1'b0;
		@(negedge clk);
		chk({mask_ack, pending_clr}, 9'h101);
		$display("test nmi done");
	endtask : t_nmi

	// With the enable low, a clear instruction must be lost and no
	// acknowledge may be given, even to a non-maskable request.
	task t_freeze;
		@(posedge clk);
		ce      <= 1'b0;
		nmi_req <= 1'b1;
		instr   <= '{1'b1, mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0};
		@(negedge clk);
		chk({exc_ack, nmi_ack, mask_ack}, 3'h0);
		@(posedge clk);
		ce          <= 1'b1;
		nmi_req     <= 1'b0;
		instr.valid <= 1'b0;
		@(negedge clk);
		chk(mask_hold_flag, 1'b1);
		$display("test freeze done");
	endtask : t_freeze

	// Source 7 is still pending from the nmi scenario; take it, then
	// reset in mid-run and check that the gate works again afterwards.
	task t_reset;
		do_op(mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0);
		chk(pending_clr, 8'h80);
		@(negedge clk);
		chk({mask_hold_flag, ack_source}, 4'hf);
		@(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		chk({mask_hold_flag, ack_source}, 4'h8);
		@(posedge clk);
		rst <= 1'b0;
		do_op(mig_pkg::MIG_OP_MASK_CLEAR, 5'h00, 32'h0);
		chk({mask_hold_flag, req_pending}, 9'h000);
		$display("test reset done");
	endtask : t_reset

	task results;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_instr();
		t_pend();
		t_nmi();
		t_freeze();
		t_reset();
		results();
	end
endmodule : tb_top
`default_nettype wire
